// ==== src/gpp_top.sv ====
/*
 General purpose I/O ports with an APB register slave. Each port has a
 direction, output value, pin level and drain mode register. Pins are split
 into input, output and output enable; the pad resolves the wire.
 Assumes a 125 MHz mclk, synchronous active-high sys_rst, and a two-wire bus
 peripheral on the same clock that only ever pulls its lines low.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gpp_cfg.svh"

module gpp_top import gpp_pkg::*; #(
   parameter int NUM_PORTS = `GPP_MAX_PORTS,
   parameter int PORT_W = `GPP_PORT_W,
   parameter logic [`GPP_MAX_PORTS*`GPP_PORT_W-1:0] BIT_PRESENT = '1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`GPP_APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pads, flattened port-major
   input wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
   output logic [NUM_PORTS*PORT_W-1:0] pin_out,
   output logic [NUM_PORTS*PORT_W-1:0] pin_oe,
   // two-wire bus peripheral
   input wire logic twi_active,
   input wire logic twi_scl_oe,
   input wire logic twi_sda_oe,
   output logic twi_scl_in,
   output logic twi_sda_in,
   // indicator lamps
   output logic indicator_lamp_one,
   output logic indicator_lamp_two
);

   localparam int NB = NUM_PORTS * PORT_W;
   localparam int SCL_IDX = `GPP_TWI_PORT * PORT_W + `GPP_TWI_SCL_BIT;
   localparam int SDA_IDX = `GPP_TWI_PORT * PORT_W + `GPP_TWI_SDA_BIT;
   localparam int LAMP_ONE_PIN = `GPP_LAMP_PORT * PORT_W + `GPP_LAMP_ONE_BIT;
   localparam int LAMP_TWO_PIN = `GPP_LAMP_PORT * PORT_W + `GPP_LAMP_TWO_BIT;

   // per-port control registers
   logic [PORT_W-1:0] data_direction_bits_q [NUM_PORTS];
   logic [PORT_W-1:0] output_drive_value_q [NUM_PORTS];
   logic [PORT_W-1:0] drain_mode_select_q [NUM_PORTS];

   // synchronised pin levels
   logic [NB-1:0] pin_lvl;

   // pad drive
   logic [NB-1:0] pin_out_d;
   logic [NB-1:0] pin_oe_d;
   logic [NB-1:0] pin_out_q;
   logic [NB-1:0] pin_oe_q;

   // bus side
   gpp_dec_t dec;
   logic setup_phase;
   logic access_wr;
   logic [PORT_W-1:0] wmask;
   logic [PORT_W-1:0] wdata;
   logic [31:0] prdata_d;
   logic [31:0] prdata_q;
   logic err_q;
   logic lamp_one_q;
   logic lamp_two_q;

   // bits that exist in a port
   function automatic logic [PORT_W-1:0] present_bits(input int p);
      logic [PORT_W-1:0] m;
      m = '0;
      for (int b = 0; b < PORT_W; b++) begin
         m[b] = BIT_PRESENT[p * PORT_W + b];
      end
      return m;
   endfunction : present_bits

   // address to port and register, with hit for mapped word addresses
   function automatic gpp_dec_t decode(input logic [`GPP_APB_AW-1:0] a);
      gpp_dec_t d;
      logic [`GPP_APB_AW-1:0] upper;
      d.port = a[`GPP_PORT_LSB +: `GPP_PORT_IDX_W];
      d.sel = gpp_reg_t'(a[`GPP_REG_LSB +: 2]);
      upper = a >> (`GPP_PORT_LSB + `GPP_PORT_IDX_W);
      d.hit = (a[`GPP_REG_LSB-1:0] == '0) && (upper == '0)
         && (int'(d.port) < NUM_PORTS)
         && (present_bits(int'(d.port)) != '0);
      return d;
   endfunction : decode

   // byte-lane merge of a write into a register
   function automatic logic [PORT_W-1:0] merge(
      input logic [PORT_W-1:0] old,
      input logic [PORT_W-1:0] nw,
      input logic [PORT_W-1:0] m
   );
      return (old & ~m) | (nw & m);
   endfunction : merge

   // input pads pass two flip-flops before any logic
   gpp_sync2 #(
      .W(NB)
   ) u_pin_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .async_in(pin_in),
      .sync_out(pin_lvl)
   );

   // apb decode; zero wait states, data settled during setup
   assign dec = decode(paddr);
   assign setup_phase = psel & ~penable;
   assign access_wr = psel & penable & pwrite & dec.hit;
   assign wdata = pwdata[PORT_W-1:0];

   always_comb begin
      wmask = '0;
      for (int b = 0; b < PORT_W; b++) begin
         wmask[b] = pstrb[b / 8];
      end
   end

   // direction registers
   always_ff @(posedge mclk) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (sys_rst) begin
            data_direction_bits_q[p] <= `GPP_RST_DIR;
         end else if (access_wr && int'(dec.port) == p && dec.sel == GPP_REG_DIR) begin
            data_direction_bits_q[p] <= merge(data_direction_bits_q[p], wdata, wmask);
         end
      end
   end

   // output value registers, written through either address
   always_ff @(posedge mclk) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (sys_rst) begin
            output_drive_value_q[p] <= `GPP_RST_OUT;
         end else if (access_wr && int'(dec.port) == p
                      && (dec.sel == GPP_REG_OUT || dec.sel == GPP_REG_LVL)) begin
            output_drive_value_q[p] <= merge(output_drive_value_q[p], wdata, wmask);
         end
      end
   end

   // drain mode registers
   always_ff @(posedge mclk) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (sys_rst) begin
            drain_mode_select_q[p] <= `GPP_RST_ODC;
         end else if (access_wr && int'(dec.port) == p && dec.sel == GPP_REG_ODC) begin
            drain_mode_select_q[p] <= merge(drain_mode_select_q[p], wdata, wmask);
         end
      end
   end

   // read data captured in the setup cycle
   always_comb begin
      prdata_d = '0;
      if (dec.hit && !pwrite) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (int'(dec.port) == p) begin
               unique case (dec.sel)
                  GPP_REG_DIR: prdata_d[PORT_W-1:0] = data_direction_bits_q[p];
                  GPP_REG_OUT: prdata_d[PORT_W-1:0] = output_drive_value_q[p];
                  GPP_REG_LVL: prdata_d[PORT_W-1:0] = pin_lvl[p * PORT_W +: PORT_W];
                  GPP_REG_ODC: prdata_d[PORT_W-1:0] = drain_mode_select_q[p];
               endcase
               // absent bits read as zero
               prdata_d[PORT_W-1:0] = prdata_d[PORT_W-1:0] & present_bits(p);
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_phase) begin
         prdata_q <= prdata_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         err_q <= 1'b0;
      end else if (setup_phase) begin
         err_q <= ~dec.hit;
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel & penable & err_q;

   // pad drive per bit, each under its own controls
   always_comb begin
      pin_out_d = '0;
      pin_oe_d = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int b = 0; b < PORT_W; b++) begin
            if (BIT_PRESENT[p * PORT_W + b] && !data_direction_bits_q[p][b]) begin
               if (drain_mode_select_q[p][b]) begin
                  // open drain: only a low is driven
                  pin_oe_d[p * PORT_W + b] = ~output_drive_value_q[p][b];
                  pin_out_d[p * PORT_W + b] = 1'b0;
               end else begin
                  pin_oe_d[p * PORT_W + b] = 1'b1;
                  pin_out_d[p * PORT_W + b] = output_drive_value_q[p][b];
               end
            end
         end
      end
      if (twi_active) begin
         // bus peripheral owns its two lines and pulls them low only
         pin_oe_d[SCL_IDX] = twi_scl_oe;
         pin_out_d[SCL_IDX] = 1'b0;
         pin_oe_d[SDA_IDX] = twi_sda_oe;
         pin_out_d[SDA_IDX] = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_oe_q <= '0;
         pin_out_q <= '0;
      end else begin
         pin_oe_q <= pin_oe_d;
         pin_out_q <= pin_out_d;
      end
   end

   assign pin_oe = pin_oe_q;
   assign pin_out = pin_out_q;

   // bus peripheral sees the synchronised line levels
   assign twi_scl_in = pin_lvl[SCL_IDX];
   assign twi_sda_in = pin_lvl[SDA_IDX];

   // lamps lit only while driven high as outputs
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         lamp_one_q <= 1'b0;
         lamp_two_q <= 1'b0;
      end else begin
         lamp_one_q <= pin_oe_d[LAMP_ONE_PIN] & pin_out_d[LAMP_ONE_PIN];
         lamp_two_q <= pin_oe_d[LAMP_TWO_PIN] & pin_out_d[LAMP_TWO_PIN];
      end
   end

   assign indicator_lamp_one = lamp_one_q;
   assign indicator_lamp_two = lamp_two_q;

endmodule : gpp_top

`default_nettype wire

// ==== src/gpp_cfg.svh ====
/*
 Constants of the general purpose I/O port block: register map, reset values,
 pin positions of the two-wire bus and the indicator lamps, port geometry.
 Assumes inclusion by bare name from the package and from the top module.
*/
// Contract
// - up to seven 16-bit ports, some bits absent
// - direction bit 0 output, 1 input
// - output value write drives all output pins; code drives open-drain pins only low, skips active bus pins
// - output value read returns last write
// - level read returns present pin levels
// - level write acts as output value write
// - drain bit 0 push-pull, 1 open-drain
// - drain mode applies to every output pin
// - every pin independently input or output
// - two-wire bus pins leave gpio while used
// - port F bits 0,1 light lamps when high; code lights them only when driven high, not when pulled up
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH

`define GPP_MAX_PORTS 7
`define GPP_PORT_W 16
`define GPP_PORT_IDX_W 3
`define GPP_APB_AW 12

// byte address = port * stride + register offset
`define GPP_PORT_LSB 4
`define GPP_REG_LSB 2
`define GPP_OFS_DIR 2'h0
`define GPP_OFS_OUT 2'h1
`define GPP_OFS_LVL 2'h2
`define GPP_OFS_ODC 2'h3

`define GPP_RST_DIR 16'hFFFF
`define GPP_RST_OUT 16'h0000
`define GPP_RST_ODC 16'h0000

// two-wire bus shares port G bits 2 and 3
`define GPP_TWI_PORT 6
`define GPP_TWI_SCL_BIT 2
`define GPP_TWI_SDA_BIT 3

// lamps sit on port F bits 0 and 1
`define GPP_LAMP_PORT 5
`define GPP_LAMP_ONE_BIT 0
`define GPP_LAMP_TWO_BIT 1

`endif

// ==== src/gpp_pkg.sv ====
/*
 Types shared by the general purpose I/O port block.
 Assumes gpp_cfg.svh on the include path.
*/
`include "gpp_cfg.svh"

package gpp_pkg;

   typedef enum logic [1:0] {
      GPP_REG_DIR = `GPP_OFS_DIR,
      GPP_REG_OUT = `GPP_OFS_OUT,
      GPP_REG_LVL = `GPP_OFS_LVL,
      GPP_REG_ODC = `GPP_OFS_ODC
   } gpp_reg_t;

   typedef struct packed {
      logic hit;
      logic [`GPP_PORT_IDX_W-1:0] port;
      gpp_reg_t sel;
   } gpp_dec_t;

endpackage : gpp_pkg

// ==== src/gpp_sync2.sv ====
/*
 Two flip-flop synchroniser for a vector of pin levels.
 Assumes each bit is an independent asynchronous level.
*/
`timescale 1ns/10ps
`default_nettype none

module gpp_sync2 #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule : gpp_sync2

`default_nettype wire

// ==== verif/gpp_pad_model.sv ====
/*
 External circuits at the pads: each wire from device drive, external driver or pull-up.
 Assumes flattened pin vectors of gpp_top.
*/
`timescale 1ns/10ps
`default_nettype none

module gpp_pad_model #(
   parameter int N = 112
) (
   // device side
   input wire logic [N-1:0] pin_out,
   input wire logic [N-1:0] pin_oe,
   // external drivers
   input wire logic [N-1:0] ext_val,
   input wire logic [N-1:0] ext_oe,
   // resolved levels
   output logic [N-1:0] pin_in
);
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_oe[i]) begin
            pin_in[i] = ext_val[i];
         end else begin
            // released lines float to the pull-up
            pin_in[i] = 1'b1;
         end
      end
   end
endmodule : gpp_pad_model

`default_nettype wire

// ==== verif/gpp_top_sva.sv ====
/*
 Port relations of gpp_top.
 Assumes bind to gpp_top, one mclk domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gpp_cfg.svh"

module gpp_top_chk #(
   parameter int NUM_PORTS = 7,
   parameter int PORT_W = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`GPP_APB_AW-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // pads
   input wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
   input wire logic [NUM_PORTS*PORT_W-1:0] pin_out,
   input wire logic [NUM_PORTS*PORT_W-1:0] pin_oe,
   // peripherals
   input wire logic twi_active,
   input wire logic twi_scl_oe,
   input wire logic twi_sda_oe,
   input wire logic twi_scl_in,
   input wire logic indicator_lamp_one,
   input wire logic indicator_lamp_two
);
   localparam int L1 = `GPP_LAMP_PORT*PORT_W+`GPP_LAMP_ONE_BIT;
   localparam int L2 = `GPP_LAMP_PORT*PORT_W+`GPP_LAMP_TWO_BIT;
   localparam int CK = `GPP_TWI_PORT*PORT_W+`GPP_TWI_SCL_BIT;
   localparam int DA = `GPP_TWI_PORT*PORT_W+`GPP_TWI_SDA_BIT;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   AST_RST_IDLE: assert property ($fell(sys_rst) |-> pin_oe == '0)
      else $error("pins driven after reset");
   AST_LAMP_ONE: assert property (indicator_lamp_one == (pin_oe[L1] & pin_out[L1]))
      else $error("lamp one wrong");
   AST_LAMP_TWO: assert property (indicator_lamp_two == (pin_oe[L2] & pin_out[L2]))
      else $error("lamp two wrong");
   AST_SCL_OWN: assert property (twi_active
      |=> !pin_out[CK] && pin_oe[CK] == $past(twi_scl_oe))
      else $error("clock pin not given to bus");
   AST_SDA_OWN: assert property (twi_active
      |=> !pin_out[DA] && pin_oe[DA] == $past(twi_sda_oe))
      else $error("data pin not given to bus");
   AST_SCL_SYNC: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
      |-> twi_scl_in == $past(pin_in[CK], 2))
      else $error("bus clock level wrong");
   // error only for unmapped words; every bit of a mapped port assumed present
   AST_ERR_PHASE: assert property (psel && penable
      |-> pslverr == (paddr[1:0] != 2'h0 || paddr[11:7] != 5'h00
      || int'(paddr[6:4]) >= NUM_PORTS))
      else $error("error response wrong");
   AST_LVL_READ: assert property (psel && !penable && !pwrite && paddr == 12'h008
      |=> prdata == {16'h0000, $past(pin_in[15:0], 3)})
      else $error("level read wrong");
endmodule : gpp_top_chk

bind gpp_top gpp_top_chk #(.NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W)) gpp_top_chk_inst (
   .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .twi_active(twi_active), .twi_scl_oe(twi_scl_oe),
   .twi_sda_oe(twi_sda_oe), .twi_scl_in(twi_scl_in),
   .indicator_lamp_one(indicator_lamp_one), .indicator_lamp_two(indicator_lamp_two));

`default_nettype wire

// ==== verif/tb_top.sv ====
/*
 Register and pin tests of gpp_top over APB.
 Assumes gpp_pad_model as the pad circuits, 125 MHz mclk.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, er, lamp1, lamp2, scl_in, sda_in;
   logic [111:0] pin_in, pin_out, pin_oe, ext_val = '0, ext_oe = '0;
   logic twi_active = 0, scl_oe = 0, sda_oe = 0;
   int fails = 0, checks = 0;

   gpp_top gpp_top_inst (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .twi_active(twi_active), .twi_scl_oe(scl_oe), .twi_sda_oe(sda_oe),
      .twi_scl_in(scl_in), .twi_sda_in(sda_in), .indicator_lamp_one(lamp1),
      .indicator_lamp_two(lamp2));
   gpp_pad_model gpp_pad_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
      .ext_oe(ext_oe), .pin_in(pin_in));

   initial begin
      forever #4 mclk = ~mclk;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s exp %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp,
      input logic eerr);
      apb(1'b0, a, 32'h0);
      chk(name, rd, exp);
      chk({name, "_err"}, {31'h0, er}, {31'h0, eerr});
   endtask : rdchk

   task automatic settle;
      repeat (5) @(posedge mclk);
   endtask : settle

   task automatic report_and_stop;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (5000) @(posedge mclk);
      fails++;
      report_and_stop;
   end

   initial begin
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int p = 0; p < 7; p++) begin
         rdchk("dir_rst", 12'(p * 16), 32'h0000FFFF, 1'b0);
      end
      rdchk("odc_rst", 12'h00C, 32'h0, 1'b0);
      rdchk("unmapped", 12'h070, 32'h0, 1'b1);
      ext_oe[15:8] <= 8'hFF;
      ext_val[15:8] <= 8'h5A;
      wr(12'h000, 32'h0000FF00);
      wr(12'h004, 32'h0000A5C3);
      settle;
      chk("oe_a", pin_oe[15:0], 32'h00FF);
      chk("out_a", pin_out[7:0], 32'hC3);
      rdchk("lvl_a", 12'h008, 32'h00005AC3, 1'b0);
      rdchk("out_rd", 12'h004, 32'h0000A5C3, 1'b0);
      wr(12'h008, 32'h00001234);
      wr(12'h00C, 32'h0000000F);
      settle;
      rdchk("out_rd2", 12'h004, 32'h00001234, 1'b0);
      chk("oe_od", pin_oe[7:0], 32'hFB);
      chk("out_od", pin_out[7:0], 32'h30);
      rdchk("lvl_od", 12'h008, 32'h00005A34, 1'b0);
      // low byte lane only
      pstrb <= 4'h1;
      wr(12'h004, 32'h0000FFFF);
      pstrb <= 4'hF;
      rdchk("out_strb", 12'h004, 32'h000012FF, 1'b0);
      wr(12'h050, 32'h0000FFFC);
      for (int i = 0; i < 3; i++) begin
         wr(12'h05C, (i == 2) ? 32'h3 : 32'h0);
         wr(12'h054, 32'(i + 1));
         settle;
         chk("lamps", {lamp2, lamp1}, (i == 2) ? 32'h0 : 32'(i + 1));
      end
      wr(12'h060, 32'h0);
      wr(12'h064, 32'h0000FFFF);
      twi_active <= 1'b1;
      scl_oe <= 1'b1;
      settle;
      chk("twi_pins", {pin_oe[99:98], pin_out[99:98]}, 32'h4);
      chk("twi_in", {sda_in, scl_in}, 32'h2);
      rdchk("lvl_g", 12'h068, 32'h0000FFFB, 1'b0);
      scl_oe <= 1'b0;
      sda_oe <= 1'b1;
      settle;
      chk("twi_sda", {pin_oe[99:98], pin_out[99:98]}, 32'h8);
      chk("twi_sda_in", {sda_in, scl_in}, 32'h1);
      twi_active <= 1'b0;
      settle;
      chk("twi_off", {pin_oe[99:98], pin_out[99:98]}, 32'hF);
      report_and_stop;
   end
endmodule : tb_top

`default_nettype wire
